// ==== common/partner_caps_pkg.sv ====
// Purpose: Shared constants for the partner capability and target remap register slice.
// Assumes: 8-bit registers on a plain strobe port, one clock at 200 MHz.
// Notes: Offsets are register addresses on the plain port.
package partner_caps_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int TGT_W = 7;

	localparam logic [7:0] OFF_CAP_ONE = 8'h35;
	localparam logic [7:0] OFF_SPARE_A = 8'h36;
	localparam logic [7:0] OFF_PARTNER = 8'h37;
	localparam logic [7:0] OFF_SPARE_B = 8'h38;
	localparam logic [7:0] OFF_TGT_ZERO = 8'h39;
	localparam logic [7:0] OFF_TGT_ONE = 8'h3A;
	localparam logic [7:0] OFF_PASS_CTRL = 8'h32;

	localparam int CAP_HOLD_BIT = 7;
	localparam int CAP_SELFTEST_BIT = 5;
	localparam int CAP_MULTI_BIT = 4;
	localparam int CAP_PORT_LSB = 0;
	localparam int CAP_PORT_W = 4;
	localparam int PASS_ENABLE_BIT = 6;
	localparam int ADDR_HOLD_BIT = 0;

	localparam logic [7:0] RST_CAP_ONE = 8'h00;
	localparam logic [7:0] RST_SPARE = 8'h00;
	localparam logic [6:0] RST_TARGET = 7'h00;
	localparam logic [7:0] RST_PASS_CTRL = 8'h00;
	// Arbitrary neutral partner address after reset.
	localparam logic [6:0] RST_PARTNER_ADDR = 7'h2A;
	localparam logic RST_ADDR_HOLD = 1'b0;

	localparam int ALIAS_SLOTS = 2;

endpackage

// ==== common/remap_if.sv ====
// Purpose: Carries one target slot between the register file and the remap slice.
// Assumes: Same clock as the register file.
// Notes: One instance per slot.
`timescale 1ns/1ps
interface remap_if;
	logic [6:0] physAddr;
	logic [6:0] aliasAddr;
	logic hit;
	modport regs (output physAddr, output aliasAddr, input hit);
	modport slot (input physAddr, input aliasAddr, output hit);
endinterface

// ==== hw/capability_hold_field.sv ====
// Purpose: One auto-loaded field with software override and a hold flag.
// Assumes: Load and write pulses are single-cycle and synchronous.
// Notes: Software write takes priority over the channel load in the same cycle.
`timescale 1ns/1ps
module capability_hold_field #(
	parameter int W = 4,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic swWrite,
	input wire logic [W-1:0] swData,
	input wire logic autoLoad,
	input wire logic [W-1:0] autoData,
	input wire logic hold,
	output logic [W-1:0] value
);
	typedef struct packed {
		logic [W-1:0] val;
	} state_s;
	state_s cur_q, cur_d;

	always_comb begin
		cur_d = cur_q;
		if (swWrite) begin
			cur_d.val = swData;
		end else if (autoLoad && !hold) begin
			cur_d.val = autoData;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cur_q.val <= RESET_VAL;
		end else begin
			cur_q <= cur_d;
		end
	end

	assign value = cur_q.val;
endmodule

// ==== hw/partner_caps_target_remap.sv ====
// Purpose: Partner capability, partner address and remote target remap registers.
// Assumes: Channel load pulses arrive synchronous to mclk after back-channel detect.
// Notes: Register reads return data the cycle after the read strobe.
//
// Contract
// - While the capability hold bit is set, channel loads of capabilities are ignored.
// - The self-test request bit shows that the partner asks for link self-test.
// - The multi-port bit reads 0 for a single-port and 1 for a multi-port partner.
// - A four-bit field reports the partner port number this serializer uses.
// - Self-test, multi-port and port fields load from the channel after link detect.
// - The seven-bit partner address normally loads from the partner over the channel.
// - While the address hold bit is set, channel loads of the partner address are ignored.
// - Each target slot holds a seven-bit physical address in its upper bits.
// - A transaction to alias slot n leaves with slot n's physical address.
// - A transaction is forwarded only with pass-through enabled and a decode match.
`timescale 1ns/1ps
module partner_caps_target_remap (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire logic linkDetected,
	input wire logic capLoad,
	input wire logic capSelftest,
	input wire logic capMultiPort,
	input wire logic [3:0] capPortNum,
	input wire logic addrLoad,
	input wire logic [6:0] addrFromPartner,
	input wire logic [13:0] aliasAddrs,
	input wire logic txnValid,
	input wire logic [6:0] txnAddr,
	output logic fwdValid,
	output logic [6:0] fwdAddr,
	output logic selftestRequest,
	output logic multiPortPartner,
	output logic [3:0] partnerPort,
	output logic [6:0] partnerAddress
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic capabilityHold;
		logic spareBit6;
		logic [7:0] spareA;
		logic [6:0] partnerAddr;
		logic partnerAddressHold;
		logic [7:0] spareB;
		logic [6:0] targetZero;
		logic [6:0] targetOne;
		logic [7:0] passCtrl;
		logic [7:0] rdata;
		logic fwdValid;
		logic [6:0] fwdAddr;
	} state_s;

	state_s cur_q, cur_d;

	logic wrCap, wrAddrReg;
	logic capLoadOk;
	logic selftestV, multiV;
	logic [3:0] portV;
	logic [1:0] slotHit;

	assign wrCap = regWrite && (regAddr == partner_caps_pkg::OFF_CAP_ONE);
	assign wrAddrReg = regWrite && (regAddr == partner_caps_pkg::OFF_PARTNER);
	// Loads only count once the back channel is up; hold blocks them too.
	assign capLoadOk = capLoad && linkDetected;

	////////////////////////////////////////////////////////////////////////////
	// The three auto-loaded fields share one override-and-hold pattern.
	capability_hold_field #(.W(1), .RESET_VAL(1'b0)) selftestField (
		.mclk(mclk),
		.reset(reset),
		.swWrite(wrCap),
		.swData(regWdata[partner_caps_pkg::CAP_SELFTEST_BIT]),
		.autoLoad(capLoadOk),
		.autoData(capSelftest),
		.hold(cur_q.capabilityHold),
		.value(selftestV)
	);

	capability_hold_field #(.W(1), .RESET_VAL(1'b0)) multiField (
		.mclk(mclk),
		.reset(reset),
		.swWrite(wrCap),
		.swData(regWdata[partner_caps_pkg::CAP_MULTI_BIT]),
		.autoLoad(capLoadOk),
		.autoData(capMultiPort),
		.hold(cur_q.capabilityHold),
		.value(multiV)
	);

	capability_hold_field #(.W(4), .RESET_VAL(4'h0)) portField (
		.mclk(mclk),
		.reset(reset),
		.swWrite(wrCap),
		.swData(regWdata[partner_caps_pkg::CAP_PORT_LSB +: partner_caps_pkg::CAP_PORT_W]),
		.autoLoad(capLoadOk),
		.autoData(capPortNum),
		.hold(cur_q.capabilityHold),
		.value(portV)
	);

	////////////////////////////////////////////////////////////////////////////
	remap_if slotLink [partner_caps_pkg::ALIAS_SLOTS] ();

	assign slotLink[0].physAddr = cur_q.targetZero;
	assign slotLink[0].aliasAddr = aliasAddrs[6:0];
	assign slotLink[1].physAddr = cur_q.targetOne;
	assign slotLink[1].aliasAddr = aliasAddrs[13:7];

	remap_slot slotZero (
		.reqAddr(txnAddr),
		.link(slotLink[0])
	);

	remap_slot slotOne (
		.reqAddr(txnAddr),
		.link(slotLink[1])
	);

	assign slotHit[0] = slotLink[0].hit;
	assign slotHit[1] = slotLink[1].hit;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		cur_d = cur_q;
		cur_d.rdata = 8'h00;
		if (regWrite) begin
			unique case (regAddr)
				partner_caps_pkg::OFF_CAP_ONE: begin
					cur_d.capabilityHold = regWdata[partner_caps_pkg::CAP_HOLD_BIT];
					cur_d.spareBit6 = regWdata[6];
				end
				partner_caps_pkg::OFF_SPARE_A: begin
					cur_d.spareA = regWdata;
				end
				partner_caps_pkg::OFF_PARTNER: begin
					cur_d.partnerAddr = regWdata[7:1];
					cur_d.partnerAddressHold = regWdata[partner_caps_pkg::ADDR_HOLD_BIT];
				end
				partner_caps_pkg::OFF_SPARE_B: begin
					cur_d.spareB = regWdata;
				end
				partner_caps_pkg::OFF_TGT_ZERO: begin
					cur_d.targetZero = regWdata[7:1];
				end
				partner_caps_pkg::OFF_TGT_ONE: begin
					cur_d.targetOne = regWdata[7:1];
				end
				partner_caps_pkg::OFF_PASS_CTRL: begin
					cur_d.passCtrl = regWdata;
				end
				default: begin
				end
			endcase
		end
		// A software write in the same cycle wins; it carries its own hold bit.
		if (addrLoad && linkDetected && !wrAddrReg && !cur_q.partnerAddressHold) begin
			cur_d.partnerAddr = addrFromPartner;
		end
		if (regRead) begin
			unique case (regAddr)
				partner_caps_pkg::OFF_CAP_ONE: begin
					cur_d.rdata = {cur_q.capabilityHold, cur_q.spareBit6, selftestV, multiV, portV};
				end
				partner_caps_pkg::OFF_SPARE_A: begin
					cur_d.rdata = cur_q.spareA;
				end
				partner_caps_pkg::OFF_PARTNER: begin
					cur_d.rdata = {cur_q.partnerAddr, cur_q.partnerAddressHold};
				end
				partner_caps_pkg::OFF_SPARE_B: begin
					cur_d.rdata = cur_q.spareB;
				end
				partner_caps_pkg::OFF_TGT_ZERO: begin
					cur_d.rdata = {cur_q.targetZero, 1'b0};
				end
				partner_caps_pkg::OFF_TGT_ONE: begin
					cur_d.rdata = {cur_q.targetOne, 1'b0};
				end
				partner_caps_pkg::OFF_PASS_CTRL: begin
					cur_d.rdata = cur_q.passCtrl;
				end
				default: begin
					cur_d.rdata = 8'h00;
				end
			endcase
		end
		// Slot zero wins when both aliases match; aliases should be distinct.
		cur_d.fwdValid = 1'b0;
		cur_d.fwdAddr = txnAddr;
		if (txnValid && cur_q.passCtrl[partner_caps_pkg::PASS_ENABLE_BIT] && (|slotHit)) begin
			cur_d.fwdValid = 1'b1;
			cur_d.fwdAddr = slotHit[0] ? slotLink[0].physAddr : slotLink[1].physAddr;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cur_q.capabilityHold <= 1'b0;
			cur_q.spareBit6 <= 1'b0;
			cur_q.spareA <= partner_caps_pkg::RST_SPARE;
			cur_q.partnerAddr <= partner_caps_pkg::RST_PARTNER_ADDR;
			cur_q.partnerAddressHold <= partner_caps_pkg::RST_ADDR_HOLD;
			cur_q.spareB <= partner_caps_pkg::RST_SPARE;
			cur_q.targetZero <= partner_caps_pkg::RST_TARGET;
			cur_q.targetOne <= partner_caps_pkg::RST_TARGET;
			cur_q.passCtrl <= partner_caps_pkg::RST_PASS_CTRL;
			cur_q.rdata <= 8'h00;
			cur_q.fwdValid <= 1'b0;
			cur_q.fwdAddr <= 7'h00;
		end else begin
			cur_q <= cur_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign regRdata = cur_q.rdata;
	assign fwdValid = cur_q.fwdValid;
	assign fwdAddr = cur_q.fwdAddr;
	assign selftestRequest = selftestV;
	assign multiPortPartner = multiV;
	assign partnerPort = portV;
	assign partnerAddress = cur_q.partnerAddr;

endmodule

// ==== hw/remap_slot.sv ====
// Purpose: Compares a local address against one alias slot.
// Assumes: Alias address comes from the alias registers outside this slice.
// Notes: Purely combinational; the top registers the result.
`timescale 1ns/1ps
module remap_slot (
	input wire logic [6:0] reqAddr,
	remap_if.slot link
);
	assign link.hit = (reqAddr == link.aliasAddr);
endmodule

// ==== verification/partner_caps_target_remap_props.sv ====
// Purpose: Checker for channel loads, holds and readback of the remap slice.
// Assumes: Hold bits are mirrored from register writes seen at the ports.
// Notes: A same-cycle write wins over a load, so such cycles are excluded.
`timescale 1ns/1ps
module partner_caps_target_remap_props (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire logic linkDetected,
	input wire logic capLoad,
	input wire logic capSelftest,
	input wire logic capMultiPort,
	input wire logic [3:0] capPortNum,
	input wire logic addrLoad,
	input wire logic [6:0] addrFromPartner,
	input wire logic selftestRequest,
	input wire logic multiPortPartner,
	input wire logic [3:0] partnerPort,
	input wire logic [6:0] partnerAddress
);
	logic capHoldQ;
	logic addrHoldQ;
	wire logic capWr = regWrite && regAddr == 8'h35;
	wire logic addrWr = regWrite && regAddr == 8'h37;
	always_ff @(posedge mclk) begin
		if (reset) begin
			capHoldQ <= 1'b0;
			addrHoldQ <= 1'b0;
		end else begin
			if (capWr) capHoldQ <= regWdata[7];
			if (addrWr) addrHoldQ <= regWdata[0];
		end
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_capTake;
		capLoad && linkDetected && !capHoldQ && !capWr;
	endsequence
	property p_capLoad;
		s_capTake |=> selftestRequest == $past(capSelftest)
			&& multiPortPartner == $past(capMultiPort) && partnerPort == $past(capPortNum);
	endproperty
	a_capLoad: assert property (p_capLoad) else $error("cap load lost");
	property p_capFrozen;
		capHoldQ && !capWr |=> $stable({selftestRequest, multiPortPartner, partnerPort});
	endproperty
	a_capFrozen: assert property (p_capFrozen) else $error("held caps moved");
	property p_addrLoad;
		addrLoad && linkDetected && !addrHoldQ && !addrWr |=>
			partnerAddress == $past(addrFromPartner);
	endproperty
	a_addrLoad: assert property (p_addrLoad) else $error("address load lost");
	property p_addrFrozen;
		addrHoldQ && !addrWr |=> $stable(partnerAddress);
	endproperty
	a_addrFrozen: assert property (p_addrFrozen) else $error("held address moved");
	property p_noLink;
		!linkDetected && !regWrite |=> $stable({partnerAddress, partnerPort, selftestRequest});
	endproperty
	a_noLink: assert property (p_noLink) else $error("load without link");
	property p_rdIdle;
		!regRead |=> regRdata == 8'h00;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
	property p_addrRead;
		regRead && regAddr == 8'h37 |=> regRdata[7:1] == $past(partnerAddress);
	endproperty
	a_addrRead: assert property (p_addrRead) else $error("address readback");
	property p_tgtBit0;
		regRead && (regAddr == 8'h39 || regAddr == 8'h3A) |=> !regRdata[0];
	endproperty
	a_tgtBit0: assert property (p_tgtBit0) else $error("target bit0 set");
endmodule
bind partner_caps_target_remap partner_caps_target_remap_props props (.*);

// ==== verification/remote_partner_model.sv ====
// Purpose: Remote partner that pushes capability and address loads.
// Assumes: Each load is a one-cycle pulse after a chosen delay.
// Notes: Idle data lines show the inverse of the last value sent.
`timescale 1ns/1ps
module remote_partner_model (
	input wire logic mclk,
	output logic linkDetected = 1'b0,
	output logic capLoad = 1'b0,
	output logic [5:0] caps = 6'h00,
	output logic addrLoad = 1'b0,
	output logic [6:0] addr = 7'h00
);
	// Inverted idle data catches a design that samples outside the pulse.
	task automatic sendCaps(input logic [5:0] c, input int gap);
		repeat (gap) @(posedge mclk);
		caps <= c;
		capLoad <= 1'b1;
		@(posedge mclk);
		capLoad <= 1'b0;
		caps <= ~c;
	endtask
	task automatic sendAddr(input logic [6:0] a, input int gap);
		repeat (gap) @(posedge mclk);
		addr <= a;
		addrLoad <= 1'b1;
		@(posedge mclk);
		addrLoad <= 1'b0;
		addr <= ~a;
	endtask
endmodule

// ==== verification/test_partner_caps_target_remap.sv ====
// Purpose: Register, channel-load and forwarding tests for the remap slice.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: The partner model drives every channel input.
`timescale 1ns/1ps
module test_partner_caps_target_remap;
	logic mclk;
	logic reset = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic txnValid = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic [13:0] aliasAddrs = 14'h0000;
	logic [6:0] txnAddr = 7'h00;
	logic [7:0] regRdata;
	logic [6:0] fwdAddr, partnerAddress, pAddr;
	logic [5:0] pCaps;
	logic [3:0] partnerPort;
	logic linkDetected, capLoad, addrLoad, fwdValid, selftestRequest, multiPortPartner;
	int miscompares = 0;
	int n_checks = 0;
	remote_partner_model pm (.mclk(mclk), .linkDetected(linkDetected), .capLoad(capLoad),
		.caps(pCaps), .addrLoad(addrLoad), .addr(pAddr));
	partner_caps_target_remap dut (.*, .capSelftest(pCaps[5]), .capMultiPort(pCaps[4]),
		.capPortNum(pCaps[3:0]), .addrFromPartner(pAddr));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		@(posedge mclk);
	endtask
	// The check waits one step so the edge that captures the read lands first.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1 chk(regRdata, exp);
		@(posedge mclk);
	endtask
	task automatic txn(input logic [6:0] a, input logic v, input logic [6:0] ea);
		txnAddr <= a;
		txnValid <= 1'b1;
		@(posedge mclk);
		txnValid <= 1'b0;
		#1 chk({7'h00, fwdValid}, {7'h00, v});
		if (v) chk({1'b0, fwdAddr}, {1'b0, ea});
		@(posedge mclk);
	endtask
	initial begin
		repeat (2000) @(posedge mclk);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd(8'h35, 8'h00);
		rd(8'h37, 8'h54);
		rd(8'h3A, 8'h00);
		rd(8'h40, 8'h00);
		$display("reset test done");
		pm.sendCaps(6'h3A, 0);
		rd(8'h35, 8'h00);
		pm.linkDetected <= 1'b1;
		pm.sendCaps(6'h3A, 3);
		rd(8'h35, 8'h3A);
		pm.sendCaps(6'h05, 0);
		rd(8'h35, 8'h05);
		wr(8'h35, 8'hB6);
		pm.sendCaps(6'h0F, 0);
		rd(8'h35, 8'hB6);
		wr(8'h35, 8'h00);
		pm.sendCaps(6'h23, 1);
		rd(8'h35, 8'h23);
		$display("capability test done");
		pm.sendAddr(7'h11, 0);
		rd(8'h37, 8'h22);
		wr(8'h37, 8'hAB);
		pm.sendAddr(7'h11, 2);
		rd(8'h37, 8'hAB);
		$display("address test done");
		wr(8'h39, 8'hFF);
		wr(8'h3A, 8'h42);
		wr(8'h40, 8'h77);
		rd(8'h39, 8'hFE);
		rd(8'h40, 8'h00);
		aliasAddrs <= {7'h21, 7'h20};
		txn(7'h20, 1'b0, 7'h00);
		wr(8'h32, 8'h40);
		txn(7'h20, 1'b1, 7'h7F);
		txn(7'h21, 1'b1, 7'h21);
		txn(7'h33, 1'b0, 7'h00);
		$display("remap test done");
		// A mid-run reset must drop the held address and the pass-through enable.
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd(8'h37, 8'h54);
		rd(8'h32, 8'h00);
		txn(7'h20, 1'b0, 7'h00);
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule
